// file: rtl/sms_pkg.sv
// Constants for the measurement sequencer: register offsets, fields, codes.
// Assumes a single 50 MHz clock and a plain strobe-style register port.
package sms_pkg;
  // Register offsets (8-bit index space)
  localparam logic [7:0] REG_IRQ_CFG   = 8'h32;
  localparam logic [7:0] REG_IRQ_PULSE = 8'h33;
  localparam logic [7:0] REG_PIN_MAP   = 8'h34;
  localparam logic [7:0] REG_CONV_CFG  = 8'h02;
  localparam logic [7:0] REG_CONV_CTL  = 8'h03;
  localparam logic [7:0] REG_INTERVAL  = 8'h0f;
  localparam logic [7:0] REG_SCAN_CFG  = 8'h13;
  localparam logic [7:0] REG_THR_FLAG  = 8'h15;
  localparam logic [7:0] REG_STATUS    = 8'h09;
  localparam logic [7:0] REG_TMIN_HI   = 8'h1e;
  localparam logic [7:0] REG_TMIN_LO   = 8'h1f;
  localparam logic [7:0] REG_TMAX_HI   = 8'h20;
  localparam logic [7:0] REG_TMAX_LO   = 8'h21;
  localparam logic [7:0] REG_RES_BASE  = 8'h36;
  localparam int         RES_SLOTS     = 5;
  // Field positions
  localparam int IRQA_SEL_LSB = 6;
  localparam int IRQB_SEL_LSB = 4;
  localparam int IMODE_LSB    = 0;
  localparam int INSEL_LSB    = 2;
  localparam int SCAN_SET_LSB = 4;
  localparam int AUTO_TEMP_BIT = 4;
  localparam int RES_AUX_L_BIT = 2;
  localparam int RES_AUX_R_BIT = 1;
  localparam int EXT_BIAS_BIT  = 0;
  localparam int RESOL_LSB    = 5;
  localparam int CDIV_LSB     = 3;
  localparam int IVAL_LSB     = 0;
  // Codes
  localparam logic [1:0] IMODE_DATA_AVAIL = 2'h1;
  localparam logic [1:0] IRQ_FN_DATA      = 2'h1;
  localparam logic [1:0] IRQ_FN_THRESH    = 2'h2;
  localparam logic [1:0] PULSE_2MS        = 2'h0;
  localparam logic [3:0] INSEL_IDLE       = 4'h0;
  localparam logic [3:0] INSEL_AUX_L      = 4'h2;
  localparam logic [3:0] INSEL_AUX_R      = 4'h3;
  localparam logic [3:0] INSEL_TEMP_LOW   = 4'h4;
  localparam logic [3:0] INSEL_TEMP_DIFF  = 4'h5;
  localparam logic [3:0] INSEL_BATTERY    = 4'h6;
  localparam logic [3:0] INSEL_AUTO_SCAN  = 4'h9;
  localparam logic [1:0] RESOL_12         = 2'h0;
  localparam logic [1:0] RESOL_10         = 2'h1;
  localparam logic [1:0] RESOL_8          = 2'h2;
  localparam int         BIAS_RATIO       = 82;
  // Pin routing: 7 pins, 2-bit source code each
  localparam int         NUM_PINS   = 7;
  localparam logic [1:0] SRC_NONE   = 2'h0;
  localparam logic [1:0] SRC_READY  = 2'h1;
  localparam logic [1:0] SRC_IRQ_A  = 2'h2;
  localparam logic [1:0] SRC_IRQ_B  = 2'h3;
  // Reset values
  localparam logic [7:0] RST_CONV_CFG = 8'h00;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [15:0] RST_TMAX    = 16'h0fff;
  // Timing
  localparam int CLK_HZ        = 50_000_000;
  localparam int PULSE_US      = 2000;
  localparam int PULSE_CYCLES  = (CLK_HZ / 1_000_000) * PULSE_US;
  localparam int INTERVAL_UNIT_US = 64;
  localparam int INTERVAL_UNIT_CYCLES = (CLK_HZ / 1_000_000) * INTERVAL_UNIT_US;
  localparam int SAMPLE_CYCLES = 4;
endpackage : sms_pkg

// file: rtl/sms_sar_core.sv
// Successive-approximation core: divides the clock, walks the bits.
// Assumes comparator input is already synchronised to CLK_I.
`timescale 1ns/10ps
module sms_sar_core
  import sms_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  wire logic [1:0]  resol_i,
  input  wire logic [1:0]  cdiv_i,
  input  wire logic        cmp_i,
  output logic             busy_o,
  output logic             done_o,
  output logic [11:0]      trial_o,
  output logic [11:0]      code_o
);
  logic [6:0]  div_q;
  logic [3:0]  bit_q;
  logic [11:0] trial_q;
  logic        busy_q;
  logic        done_q;
  logic [11:0] code_q;
  wire  [3:0]  nbits   = (resol_i == RESOL_8)  ? 4'h8 :
                         (resol_i == RESOL_10) ? 4'ha : 4'hc;
  wire  [6:0]  div_top = (7'h1 << cdiv_i) - 7'h1;
  // Floor of three cycles covers the comparator synchroniser
  wire  [6:0]  div_end = (div_top < 7'h2) ? 7'h2 : div_top;
  wire         tick    = (div_q == div_end);
  wire  [11:0] bitmask = 12'h800 >> (4'hc - nbits + bit_q);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q   <= 7'h00;
      bit_q   <= 4'h0;
      trial_q <= 12'h000;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      code_q  <= 12'h000;
    end else begin
      done_q <= 1'b0;
      if (start_i && !busy_q) begin
        busy_q  <= 1'b1;
        bit_q   <= 4'h0;
        div_q   <= 7'h00;
        trial_q <= 12'h800 >> (4'hc - nbits);
      end else if (busy_q) begin
        div_q <= tick ? 7'h00 : div_q + 7'h01;
        if (tick) begin
          if (bit_q == nbits - 4'h1) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            code_q <= cmp_i ? trial_q : (trial_q & ~bitmask);
          end else begin
            bit_q   <= bit_q + 4'h1;
            trial_q <= (cmp_i ? trial_q : (trial_q & ~bitmask))
                       | (bitmask >> 1);
          end
        end
      end
    end
  end

  assign busy_o  = busy_q;
  assign done_o  = done_q;
  assign trial_o = trial_q;
  assign code_o  = code_q;
endmodule : sms_sar_core

// file: rtl/sms_sequencer.sv
// Measurement sequencer: register file, mode control, scan, thresholds,
// interrupt outputs and pin routing. Comparator input is asynchronous.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
// Summary of operation
// - Interrupt config register holds output A select [7:6], B select [5:4].
// - Data-available interrupt enabled only when control mode field is 01.
// - Ready and both interrupts routable to any of seven pins.
// - Single temperature reading, or differential pair with 82x bias.
// - Auto-temperature bit starts temperature readings each interval in host-controlled operation.
// - Temperature result compared to min/max; outside sets a flag.
// - Threshold flag register read-only, cleared after host reads it.
// - Threshold interrupt with pulse field 00 gives about 2 ms high pulse.
// - Temperature conversions in host-controlled operation, and in auto-scan when scan bit 7 is set.
// - Input select 0110 enters battery-voltage measurement.
// - Battery and auxiliary conversions at 8, 10 or 12 bits.
// - Scan bits 2 and 1 put left/right aux in resistance mode.
// - Scan bit 0 selects external bias resistor for resistance mode.
// - Input select 1001 is auto-scan; scan bits 7:4 pick inputs.
// - Auto-scan converts each chosen input in turn, repeating.
// - Interval field 3:0 sets delay between successive scan sets.
// - Results are unsigned, zero-extended to 16 bits in two bytes.
// - Resolution chosen by converter config bits 6:5.
// - Conversion clock divide ratio chosen by config bits 4:3.
module sms_sequencer
  import sms_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [7:0]  RDATA_O,
  input  wire logic        CMP_I,
  output logic      [11:0] TRIAL_O,
  output logic      [2:0]  CHAN_O,
  output logic             HIGH_BIAS_O,
  output logic             RES_MODE_O,
  output logic             EXT_BIAS_O,
  output logic             IRQ_OUT_A_O,
  output logic             IRQ_OUT_B_O,
  output logic      [NUM_PINS-1:0] PIN_O
);
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_CONV   = 4'b0100,
    ST_WAIT   = 4'b1000
  } sms_state_e;

  // Channel codes, also result slot index
  localparam logic [2:0] CH_AUX_L = 3'h0;
  localparam logic [2:0] CH_AUX_R = 3'h1;
  localparam logic [2:0] CH_BATT  = 3'h2;
  localparam logic [2:0] CH_TEMPERATURE_LOW_BIAS = 3'h3;
  localparam logic [2:0] CH_TEMPERATURE_HIGH_BIAS = 3'h4;

  function automatic logic rd_hit(input logic [7:0] a, input logic [7:0] r);
    rd_hit = (a == r);
  endfunction : rd_hit

  logic [7:0]  irq_cfg_q, irq_pulse_q, conv_cfg_q, conv_ctl_q;
  logic [7:0]  interval_q, scan_cfg_q;
  logic [7:0]  tmin_hi_q, tmin_lo_q, tmax_hi_q, tmax_lo_q;
  logic [13:0] pin_map_q;
  logic [11:0] res_q [RES_SLOTS];
  logic [RES_SLOTS-1:0] avail_q;
  logic [1:0]  thr_flag_q;
  logic        cmp_m_q, cmp_s_q;
  sms_state_e  state_q;
  logic [2:0]  chan_q;
  logic [3:0]  scan_idx_q;
  logic [23:0] wait_q;
  logic [2:0]  samp_q;
  logic        ready_q;
  logic [16:0] pulse_q;
  logic [7:0]  rdata_q;
  logic        start_conv;
  logic        conv_done;
  logic [11:0] conv_code;
  logic        conv_busy;

  // Decoded fields
  wire [1:0]  irqa_fn   = irq_cfg_q[IRQA_SEL_LSB +: 2];
  wire [1:0]  irqb_fn   = irq_cfg_q[IRQB_SEL_LSB +: 2];
  wire [1:0]  imode     = conv_ctl_q[IMODE_LSB +: 2];
  wire [3:0]  insel     = conv_ctl_q[INSEL_LSB +: 4];
  wire [3:0]  scan_set  = scan_cfg_q[SCAN_SET_LSB +: 4];
  wire        auto_temp = scan_cfg_q[AUTO_TEMP_BIT];
  wire [3:0]  ival      = interval_q[IVAL_LSB +: 4];
  wire [1:0]  resol     = conv_cfg_q[RESOL_LSB +: 2];
  wire [1:0]  cdiv      = conv_cfg_q[CDIV_LSB +: 2];
  wire        host_ctl  = (insel != INSEL_AUTO_SCAN);
  wire        dav_en    = (imode == IMODE_DATA_AVAIL);
  wire        scanning  = (insel == INSEL_AUTO_SCAN);
  wire        single_req = WR_I && rd_hit(ADDR_I, REG_CONV_CTL)
                           && (WDATA_I[INSEL_LSB +: 4] != INSEL_IDLE)
                           && (WDATA_I[INSEL_LSB +: 4] != INSEL_AUTO_SCAN);
  wire [3:0]  req_sel   = WDATA_I[INSEL_LSB +: 4];
  wire [23:0] wait_top  = 24'(ival) * 24'(INTERVAL_UNIT_CYCLES)
                          + 24'(INTERVAL_UNIT_CYCLES);
  wire [15:0] tmin      = {tmin_hi_q, tmin_lo_q};
  wire [15:0] tmax      = {tmax_hi_q, tmax_lo_q};
  wire        is_temp   = (chan_q == CH_TEMPERATURE_LOW_BIAS) || (chan_q == CH_TEMPERATURE_HIGH_BIAS);
  wire        too_low   = ({4'h0, conv_code} < tmin);
  wire        too_high  = ({4'h0, conv_code} > tmax);
  wire        thr_event = conv_done && is_temp && (too_low || too_high);
  wire [7:0]  res_idx   = ADDR_I - REG_RES_BASE;
  wire [2:0]  res_slot  = res_idx[3:1];
  wire        res_hit   = (ADDR_I >= REG_RES_BASE)
                          && (res_idx < 8'(2 * RES_SLOTS));
  wire        thr_rd    = RD_I && rd_hit(ADDR_I, REG_THR_FLAG);
  wire        res_lo_rd = RD_I && res_hit && res_idx[0];
  wire        pulse_mode = (irq_pulse_q[7:6] == PULSE_2MS);
  wire        thr_pulse = (pulse_q != 17'h0);
  wire        irq_a_d   = (irqa_fn == IRQ_FN_DATA)   ? (ready_q & dav_en)
                        : (irqa_fn == IRQ_FN_THRESH) ? thr_pulse : 1'b0;
  wire        irq_b_d   = (irqb_fn == IRQ_FN_DATA)   ? (ready_q & dav_en)
                        : (irqb_fn == IRQ_FN_THRESH) ? thr_pulse : 1'b0;

  // Next scan channel among the chosen set, searching from scan_idx_q
  logic [2:0] scan_ch;
  logic [3:0] scan_nidx;
  logic       scan_any;
  always_comb begin
    scan_ch   = CH_AUX_L;
    scan_nidx = 4'h0;
    scan_any  = 1'b0;
    for (int k = 3; k >= 0; k--) begin
      if (scan_set[k] && (4'(k) >= scan_idx_q)) begin
        scan_ch   = 3'(k);
        scan_nidx = 4'(k + 1);
        scan_any  = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_cfg_q   <= RST_ZERO;
      irq_pulse_q <= RST_ZERO;
      conv_cfg_q  <= RST_CONV_CFG;
      conv_ctl_q  <= RST_ZERO;
      interval_q  <= RST_ZERO;
      scan_cfg_q  <= RST_ZERO;
      tmin_hi_q   <= RST_ZERO;
      tmin_lo_q   <= RST_ZERO;
      tmax_hi_q   <= RST_TMAX[15:8];
      tmax_lo_q   <= RST_TMAX[7:0];
      pin_map_q   <= 14'h0000;
    end else if (WR_I) begin
      case (ADDR_I)
        REG_IRQ_CFG:   irq_cfg_q   <= WDATA_I;
        REG_IRQ_PULSE: irq_pulse_q <= WDATA_I;
        REG_CONV_CFG:  conv_cfg_q  <= WDATA_I;
        REG_CONV_CTL:  conv_ctl_q  <= WDATA_I;
        REG_INTERVAL:  interval_q  <= WDATA_I;
        REG_SCAN_CFG:  scan_cfg_q  <= WDATA_I;
        REG_TMIN_HI:   tmin_hi_q   <= WDATA_I;
        REG_TMIN_LO:   tmin_lo_q   <= WDATA_I;
        REG_TMAX_HI:   tmax_hi_q   <= WDATA_I;
        REG_TMAX_LO:   tmax_lo_q   <= WDATA_I;
        REG_PIN_MAP:   pin_map_q   <= {WDATA_I[5:0], WDATA_I};
        default: ;
      endcase
    end
  end

  // Sequencing of conversions
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q    <= ST_IDLE;
      chan_q     <= CH_AUX_L;
      scan_idx_q <= 4'h0;
      wait_q     <= 24'h0;
      samp_q     <= 3'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          samp_q <= 3'h0;
          if (single_req) begin
            state_q <= ST_SAMPLE;
            case (req_sel)
              INSEL_AUX_L:     chan_q <= CH_AUX_L;
              INSEL_AUX_R:     chan_q <= CH_AUX_R;
              INSEL_BATTERY:   chan_q <= CH_BATT;
              INSEL_TEMP_DIFF: chan_q <= CH_TEMPERATURE_LOW_BIAS;
              default:         chan_q <= CH_TEMPERATURE_LOW_BIAS;
            endcase
          end else if (scanning && scan_any) begin
            chan_q     <= scan_ch;
            scan_idx_q <= scan_nidx;
            state_q    <= ST_SAMPLE;
          end else if (scanning) begin
            scan_idx_q <= 4'h0;
            wait_q     <= 24'h0;
            state_q    <= ST_WAIT;
          end else if (auto_temp && host_ctl) begin
            wait_q  <= 24'h0;
            state_q <= ST_WAIT;
          end
        end
        ST_SAMPLE: begin
          samp_q <= samp_q + 3'h1;
          if (samp_q == 3'(SAMPLE_CYCLES - 1)) state_q <= ST_CONV;
        end
        ST_CONV: begin
          samp_q <= 3'h0;
          if (conv_done) begin
            if (chan_q == CH_TEMPERATURE_LOW_BIAS && insel == INSEL_TEMP_DIFF) begin
              chan_q  <= CH_TEMPERATURE_HIGH_BIAS;
              state_q <= ST_SAMPLE;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_WAIT: begin
          wait_q <= wait_q + 24'h1;
          if (!scanning && !auto_temp) begin
            state_q <= ST_IDLE;
          end else if (wait_q >= wait_top) begin
            state_q <= scanning ? ST_IDLE : ST_SAMPLE;
            chan_q  <= scanning ? chan_q : CH_TEMPERATURE_LOW_BIAS;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign start_conv = (state_q == ST_CONV) && !conv_busy && !conv_done;

  sms_sar_core u_core (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .start_i (start_conv),
    .resol_i (resol),
    .cdiv_i  (cdiv),
    .cmp_i   (cmp_s_q),
    .busy_o  (conv_busy),
    .done_o  (conv_done),
    .trial_o (TRIAL_O),
    .code_o  (conv_code)
  );

  // Results, flags and interrupts
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cmp_m_q    <= 1'b0;
      cmp_s_q    <= 1'b0;
      for (int i = 0; i < RES_SLOTS; i++) res_q[i] <= 12'h000;
      avail_q    <= '0;
      thr_flag_q <= 2'h0;
      ready_q    <= 1'b0;
      pulse_q    <= 17'h0;
    end else begin
      cmp_m_q <= CMP_I;
      cmp_s_q <= cmp_m_q;
      if (res_lo_rd && res_slot < 3'(RES_SLOTS))
        avail_q[res_slot] <= 1'b0;
      if (conv_done) begin
        res_q[chan_q]   <= conv_code;
        avail_q[chan_q] <= 1'b1;
      end
      // Set beats the clear-on-read
      thr_flag_q <= (thr_rd ? 2'h0 : thr_flag_q)
                  | (thr_event ? {too_high, too_low} : 2'h0);
      ready_q <= conv_done ? 1'b1 : (res_lo_rd ? 1'b0 : ready_q);
      if (thr_event && pulse_mode)
        pulse_q <= 17'(PULSE_CYCLES);
      else if (pulse_q != 17'h0)
        pulse_q <= pulse_q - 17'h1;
    end
  end

  // Register read path
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rdata_q <= 8'h00;
    end else if (RD_I) begin
      if (res_hit && res_slot < 3'(RES_SLOTS))
        rdata_q <= res_idx[0] ? res_q[res_slot][7:0]
                              : {4'h0, res_q[res_slot][11:8]};
      else begin
        case (ADDR_I)
          REG_IRQ_CFG:   rdata_q <= irq_cfg_q;
          REG_IRQ_PULSE: rdata_q <= irq_pulse_q;
          REG_CONV_CFG:  rdata_q <= conv_cfg_q;
          REG_CONV_CTL:  rdata_q <= conv_ctl_q;
          REG_INTERVAL:  rdata_q <= interval_q;
          REG_SCAN_CFG:  rdata_q <= scan_cfg_q;
          REG_TMIN_HI:   rdata_q <= tmin_hi_q;
          REG_TMIN_LO:   rdata_q <= tmin_lo_q;
          REG_TMAX_HI:   rdata_q <= tmax_hi_q;
          REG_TMAX_LO:   rdata_q <= tmax_lo_q;
          REG_PIN_MAP:   rdata_q <= pin_map_q[7:0];
          REG_THR_FLAG:  rdata_q <= {6'h00, thr_flag_q};
          REG_STATUS:    rdata_q <= {1'b0, state_q == ST_IDLE,
                                     ready_q, avail_q};
          default:       rdata_q <= 8'h00;
        endcase
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Pin routing, two bits per pin
  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_pin
      wire [1:0] src = pin_map_q[2*p +: 2];
      assign PIN_O[p] = (src == SRC_READY) ? ready_q
                      : (src == SRC_IRQ_A) ? IRQ_OUT_A_O
                      : (src == SRC_IRQ_B) ? IRQ_OUT_B_O : 1'b0;
    end
  endgenerate

  assign IRQ_OUT_A_O = irq_a_d;
  assign IRQ_OUT_B_O = irq_b_d;
  assign RDATA_O     = rdata_q;
  assign CHAN_O      = chan_q;
  assign HIGH_BIAS_O = (chan_q == CH_TEMPERATURE_HIGH_BIAS);
  assign RES_MODE_O  = (chan_q == CH_AUX_L && scan_cfg_q[RES_AUX_L_BIT])
                    || (chan_q == CH_AUX_R && scan_cfg_q[RES_AUX_R_BIT]);
  assign EXT_BIAS_O  = RES_MODE_O && scan_cfg_q[EXT_BIAS_BIT];
endmodule : sms_sequencer

// file: verif/sms_afe_model.sv
// Analog front end seen by the sequencer: one comparator per channel.
// Assumes trial codes are full 12-bit and channel codes 0..4.
`timescale 1ns/10ps
module sms_afe_model (
  input  wire logic [11:0] trial_i,
  input  wire logic [2:0]  chan_i,
  input  wire logic [59:0] levels_i,
  output logic             cmp_o
);
  // Input at or above trial keeps the bit; unused channels read low
  assign cmp_o = (chan_i <= 3'h4) && (levels_i[chan_i*12 +: 12] >= trial_i);
endmodule : sms_afe_model

// file: verif/sms_sequencer_asserts.sv
// Port-level checks for the measurement sequencer.
// Assumes one clock domain and asynchronous active-low reset.
`timescale 1ns/10ps
module sms_sequencer_chk
  import sms_pkg::*;
(
  input wire logic                CLK_I,
  input wire logic                RST_N_I,
  input wire logic [7:0]          ADDR_I,
  input wire logic [7:0]          WDATA_I,
  input wire logic                WR_I,
  input wire logic                RD_I,
  input wire logic [7:0]          RDATA_O,
  input wire logic                CMP_I,
  input wire logic [11:0]         TRIAL_O,
  input wire logic [2:0]          CHAN_O,
  input wire logic                HIGH_BIAS_O,
  input wire logic                RES_MODE_O,
  input wire logic                EXT_BIAS_O,
  input wire logic                IRQ_OUT_A_O,
  input wire logic                IRQ_OUT_B_O,
  input wire logic [NUM_PINS-1:0] PIN_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire res_hi = (ADDR_I >= REG_RES_BASE) && !ADDR_I[0] &&
                (ADDR_I < REG_RES_BASE + 8'(2 * RES_SLOTS));
  wire rd_flag = RD_I && (ADDR_I == REG_THR_FLAG);
  rd_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data not zero outside read answer");
  unmapped_rd_a: assert property (RD_I && ADDR_I == 8'hff |=> RDATA_O == 8'h00)
    else $error("unmapped read returned data");
  hi_byte_a: assert property (RD_I && res_hi |=> RDATA_O[7:4] == 4'h0)
    else $error("result high byte not zero extended");
  reg_echo_a: assert property (WR_I && ADDR_I == REG_INTERVAL ##1
    RD_I && ADDR_I == REG_INTERVAL |=> RDATA_O[3:0] == $past(WDATA_I[3:0], 2))
    else $error("interval field not read back");
  flag_clear_a: assert property (rd_flag ##1 rd_flag |=> RDATA_O == 8'h00)
    else $error("threshold flag not cleared by read");
  flag_width_a: assert property (rd_flag |=> RDATA_O[7:2] == 6'h00)
    else $error("threshold flag register has stray bits");
  high_bias_a: assert property (HIGH_BIAS_O |-> CHAN_O == 3'h4)
    else $error("high bias outside high bias channel");
  res_chan_a: assert property (RES_MODE_O |-> CHAN_O <= 3'h1)
    else $error("resistance mode on a non aux channel");
  chan_range_a: assert property (CHAN_O <= 3'h4)
    else $error("channel code out of range");
  cover property ($rose(IRQ_OUT_A_O));
  cover property ($rose(HIGH_BIAS_O));
  cover property ($rose(IRQ_OUT_B_O));
endmodule : sms_sequencer_chk

bind sms_sequencer sms_sequencer_chk u_chk (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .CMP_I(CMP_I),
  .TRIAL_O(TRIAL_O), .CHAN_O(CHAN_O), .HIGH_BIAS_O(HIGH_BIAS_O),
  .RES_MODE_O(RES_MODE_O), .EXT_BIAS_O(EXT_BIAS_O),
  .IRQ_OUT_A_O(IRQ_OUT_A_O), .IRQ_OUT_B_O(IRQ_OUT_B_O), .PIN_O(PIN_O)
);

// file: verif/sms_sequencer_tb_top.sv
// Self-checking bench for the measurement sequencer.
// Assumes the comparator model and the bound checker are compiled too.
`timescale 1ns/10ps
module sms_sequencer_tb_top;
  import sms_pkg::*;
  logic                CLK_I, RST_N_I, WR_I, RD_I, CMP_I, rd_seen, ival_ok;
  logic [7:0]          ADDR_I, WDATA_I, RDATA_O;
  logic [11:0]         TRIAL_O;
  logic [2:0]          CHAN_O;
  logic                HIGH_BIAS_O, RES_MODE_O, EXT_BIAS_O;
  logic                IRQ_OUT_A_O, IRQ_OUT_B_O;
  logic [NUM_PINS-1:0] PIN_O;
  logic [11:0]         lvl [5];
  logic [59:0]         levels;
  logic [7:0]          exp_q [$], msk_q [$];
  logic [31:0]         lfsr_q;
  logic [3:0]          codes [4];
  int                  mismatches, num_checks, n;

  assign levels = {lvl[4], lvl[3], lvl[2], lvl[1], lvl[0]};
  sms_sequencer DUT (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .CMP_I(CMP_I),
    .TRIAL_O(TRIAL_O), .CHAN_O(CHAN_O), .HIGH_BIAS_O(HIGH_BIAS_O),
    .RES_MODE_O(RES_MODE_O), .EXT_BIAS_O(EXT_BIAS_O),
    .IRQ_OUT_A_O(IRQ_OUT_A_O), .IRQ_OUT_B_O(IRQ_OUT_B_O), .PIN_O(PIN_O));
  sms_afe_model u_afe (.trial_i(TRIAL_O), .chan_i(CHAN_O),
    .levels_i(levels), .cmp_o(CMP_I));

  initial begin
    CLK_I = 1'b0;
    forever #10 CLK_I = ~CLK_I;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  task automatic cmp_rd(input logic [7:0] e, m, g);
    num_checks++;
    if ((g & m) !== (e & m)) begin
      mismatches++;
      $display("unexpected read data expected %h seen %h", e, g);
    end
  endtask : cmp_rd

  task automatic cmp_out(input string nm, input logic [6:0] e, g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_out

  // Read answers are matched one edge after the strobe is sampled
  always @(posedge CLK_I) begin
    if (rd_seen) cmp_rd(exp_q.pop_front(), msk_q.pop_front(), RDATA_O);
    rd_seen = RD_I && RST_N_I;
  end

  task automatic wr(input logic [7:0] a, d);
    WR_I <= 1'b1;
    RD_I <= 1'b0;
    ADDR_I <= a;
    WDATA_I <= d;
    @(posedge CLK_I);
  endtask : wr

  task automatic rd(input logic [7:0] a, e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    WR_I <= 1'b0;
    RD_I <= 1'b1;
    ADDR_I <= a;
    @(posedge CLK_I);
  endtask : rd

  task automatic idle(input int c);
    WR_I <= 1'b0;
    RD_I <= 1'b0;
    repeat (c) @(posedge CLK_I);
  endtask : idle

  task automatic rd_res(input int s, input logic [11:0] e,
                        input logic [7:0] mh, ml);
    rd(REG_RES_BASE + 8'(2 * s), {4'h0, e[11:8]}, mh);
    rd(REG_RES_BASE + 8'(2 * s + 1), e[7:0], ml);
  endtask : rd_res

  // Wait on data irq (0), high bias (1) or channel code v (2)
  task automatic wait_on(input int sel, input logic [2:0] v, input int lim);
    idle(0);
    n = 0;
    while (!(sel == 0 ? IRQ_OUT_A_O === 1'b1 : sel == 1 ?
             HIGH_BIAS_O === 1'b1 : CHAN_O === v)) begin
      @(posedge CLK_I);
      n++;
      if (n >= lim) begin
        mismatches++;
        $display("unexpected wait %0d expected done seen timeout", sel);
        report_and_stop();
      end
    end
  endtask : wait_on

  initial begin
    {RST_N_I, WR_I, RD_I} = 3'h0;
    {ADDR_I, WDATA_I} = 16'h0000;
    lfsr_q = 32'h7d13;
    codes = '{INSEL_AUX_L, INSEL_AUX_R, INSEL_BATTERY, INSEL_TEMP_LOW};
    foreach (lvl[i]) begin
      lfsr_q = lfsr_next(lfsr_q);
      lvl[i] = lfsr_q[11:0];
    end
    repeat (16) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    @(posedge CLK_I);
    wr(REG_IRQ_CFG, 8'h40);
    rd(REG_IRQ_CFG, 8'h40, 8'hf0);
    wr(REG_INTERVAL, 8'h03);
    rd(REG_INTERVAL, 8'h03, 8'h0f);
    rd(8'hff, 8'h00, 8'hff);
    idle(2);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(REG_CONV_CTL, {2'b00, codes[i], IMODE_DATA_AVAIL});
      wait_on(0, 3'h0, 2000);
      rd_res(i, lvl[i], 8'hff, 8'hff);
      idle(2);
      cmp_out("irq a", 7'h00, {6'h0, IRQ_OUT_A_O});
    end
    wr(REG_CONV_CTL, {2'b00, INSEL_TEMP_DIFF, IMODE_DATA_AVAIL});
    wait_on(1, 3'h0, 2000);
    idle(200);
    rd(REG_RES_BASE + 8'h07, lvl[3][7:0], 8'hff);
    rd_res(4, lvl[4], 8'hff, 8'hff);
    $display("test conversions done");
    for (int j = 0; j < 2; j++) begin
      wr(REG_CONV_CFG, j == 0 ? 8'h20 : 8'h58);
      wr(REG_CONV_CTL, {2'b00, INSEL_BATTERY, IMODE_DATA_AVAIL});
      idle(40);
      if (j == 1) cmp_out("irq a", 7'h00, {6'h0, IRQ_OUT_A_O});
      wait_on(0, 3'h0, 2000);
      rd_res(2, 12'h000, j == 0 ? 8'hfc : 8'hff, 8'h00);
    end
    wr(REG_CONV_CFG, 8'h00);
    wr(REG_CONV_CTL, {2'b00, INSEL_BATTERY, 2'b00});
    idle(300);
    cmp_out("irq a", 7'h00, {6'h0, IRQ_OUT_A_O});
    rd(REG_RES_BASE + 8'h05, lvl[2][7:0], 8'hff);
    wr(REG_SCAN_CFG, 8'h05);
    wr(REG_CONV_CTL, {2'b00, INSEL_AUX_L, IMODE_DATA_AVAIL});
    idle(2);
    cmp_out("bias", 7'h03, {5'h0, RES_MODE_O, EXT_BIAS_O});
    wait_on(0, 3'h0, 2000);
    rd(REG_RES_BASE + 8'h01, lvl[0][7:0], 8'hff);
    wr(REG_SCAN_CFG, 8'h00);
    $display("test modes done");
    wr(REG_TMIN_HI, 8'h01);
    wr(REG_TMIN_LO, 8'h00);
    wr(REG_IRQ_CFG, 8'h60);
    lvl[3] = 12'h050;
    wr(REG_CONV_CTL, {2'b00, INSEL_TEMP_LOW, IMODE_DATA_AVAIL});
    wait_on(0, 3'h0, 2000);
    idle(2);
    cmp_out("irq b", 7'h01, {6'h0, IRQ_OUT_B_O});
    foreach (codes[k]) begin
      wr(REG_PIN_MAP, k == 0 ? 8'hff : k == 1 ? 8'haa : k == 2 ? 8'h55 : 8'h00);
      idle(2);
      cmp_out("pins", k == 3 ? 7'h00 : 7'h7f, PIN_O);
    end
    rd(REG_THR_FLAG, 8'h01, 8'hff);
    rd(REG_THR_FLAG, 8'h00, 8'hff);
    wr(REG_THR_FLAG, 8'hff);
    rd(REG_THR_FLAG, 8'h00, 8'hff);
    rd_res(3, 12'h050, 8'hff, 8'hff);
    wr(REG_PIN_MAP, 8'haa);
    idle(2);
    cmp_out("pins", 7'h00, PIN_O);
    idle(1000);
    cmp_out("irq b", 7'h01, {6'h0, IRQ_OUT_B_O});
    $display("test threshold done");
    wr(REG_INTERVAL, 8'h00);
    wr(REG_SCAN_CFG, 8'h60);
    wr(REG_CONV_CTL, {2'b00, INSEL_AUTO_SCAN, IMODE_DATA_AVAIL});
    wait_on(2, 3'h1, 2000);
    wait_on(2, 3'h2, 8000);
    wait_on(2, 3'h1, 8000);
    ival_ok = (n >= INTERVAL_UNIT_CYCLES) && (n < INTERVAL_UNIT_CYCLES + 200);
    cmp_out("interval", 7'h01, {6'h0, ival_ok});
    wr(REG_CONV_CTL, 8'h00);
    wr(REG_SCAN_CFG, 8'h10);
    wait_on(2, 3'h3, 8000);
    wr(REG_SCAN_CFG, 8'h00);
    idle(20);
    $display("test scan done");
    report_and_stop();
  end
endmodule : sms_sequencer_tb_top
